/* hdl/flk_cfg.svh */
// Register indexes, field positions, reset values and fixed codes of the lockout block
`ifndef FLK_CFG_SVH
`define FLK_CFG_SVH

// Register indexes; byte address is four times the index
`define FLK_IDX_LOCK      10'h101
`define FLK_IDX_CIDX      10'h102
`define FLK_IDX_SPARE     10'h103
`define FLK_IDX_CFG       10'h104
`define FLK_IDX_FIRQ      10'h105
`define FLK_IDX_OPST      10'h106
`define FLK_IDX_FSTS      10'h107
`define FLK_IDX_CWORD     10'h10a
`define FLK_IDX_CAPT      10'h120

// Nonvolatile lockout byte location and reset contents
`define FLK_LOCK_ADDR     18'h3ff0f
`define FLK_LOCK_RST      8'hff
`define FLK_LOCK_ALL      8'hff
`define FLK_PAT_ON        2'b10

// Lockout fields
`define FLK_KEY_HI        7
`define FLK_KEY_LO        6
`define FLK_PROT_HI       1
`define FLK_PROT_LO       0

// Configuration, interrupt enable and status fields
`define FLK_CFG_CMDIE     7
`define FLK_CFG_IGNORE_SINGLE_FAULT     4
`define FLK_CFG_FDF       1
`define FLK_CFG_FSF       0
`define FLK_FIRQ_DIE      1
`define FLK_FIRQ_SIE      0
`define FLK_OPST_DONE     7
`define FLK_FSTS_DF       1
`define FLK_FSTS_SF       0

// Reset values and widths
`define FLK_CIDX_W        3
`define FLK_CIDX_RST      3'h0
`define FLK_CFG_RST       1'b0
`define FLK_CWORD_W       16
`define FLK_CAPT_W        18

// Bus answers
`define FLK_RESP_OKAY     2'b00
`define FLK_RESP_SLVERR   2'b10

`endif

/* hdl/flk_pkg.sv */
// Types shared by the lockout block
package flk_pkg;
   typedef enum logic [2:0] {
      LD_START = 3'b001,
      LD_REQ   = 3'b010,
      LD_DONE  = 3'b100
   } flk_load_t;
   typedef logic [1:0] flk_resp_t;
endpackage

/* hdl/flk_cmd_mem.sv */
// Command word array with registered read port
`timescale 1ns/1ps
module flk_cmd_mem
   import flk_pkg::*;
(
   input  wire logic        clk_i,    // Bus clock
   input  wire logic        nrst_i,   // Sync reset, active low
   input  wire logic        we_i,     // Write enable
   input  wire logic [1:0]  wbe_i,    // Byte enables
   input  wire logic [2:0]  waddr_i,  // Write word index
   input  wire logic [15:0] wdata_i,  // Write data
   input  wire logic        re_i,     // Read enable
   input  wire logic [2:0]  raddr_i,  // Read word index
   output logic      [15:0] rdata_o   // Registered read data
);
   logic [7:0] lane_mem [0:1][0:7];

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (we_i && wbe_i[b]) begin
               lane_mem[b][waddr_i] <= wdata_i[b*8 +: 8];
            end
         end
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               rdata_o[b*8 +: 8] <= 8'h00;
            end else if (re_i) begin
               rdata_o[b*8 +: 8] <= lane_mem[b][raddr_i];
            end
         end
      end
   endgenerate
endmodule

/* hdl/flk_lockout.sv */
// Lockout state, command index and fault configuration registers behind AXI4-Lite
// What this block does
// - Lockout register reads fully; every software write to it is ignored.
// - Reset sequence loads lockout register from the nonvolatile byte at 0x3_FF0F.
// - Double fault while loading that byte sets every lockout bit.
// - Backdoor key field, bits 7-6, means enabled only for pattern 10.
// - Protection field, bits 1-0, means unlocked only for pattern 10.
// - Backdoor unlock forces the protection field to 10.
// - Command index selects which command array word an access reaches.
// - Only the index field of the command index register is writable; rest reads zero.
// - Factory test spare register reads zero and ignores writes.
// - Command done enable, bit 7, requests an interrupt while done flag set.
// - Ignore-single-fault bit 4 suppresses single fault reporting and its interrupt.
// - Force double fault bit 1 makes every array read set the double flag.
// - Without forcing, the double flag sets only on real double faults.
// - Forced double faults leave the capture register unchanged.
// - Force double fault bit clears only by software writing zero.
// - Force single fault bit 0 makes every array read set the single flag unless ignore bit 4 is set.
// - Forced single faults leave the capture register unchanged.
// - Force single fault bit clears only by software writing zero.
// - Only enable, ignore and the two force bits of config are writable.
// - Done flag low while a command runs; writing one while the flag is set launches a command.
// - Fault interrupt enables request interrupts while their flags are set.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "flk_cfg.svh"
module flk_lockout
   import flk_pkg::*;
(
   input  wire logic        clk_i,             // Bus clock, 40 MHz
   input  wire logic        nrst_i,            // Sync reset, active low
   input  wire logic [11:0] s_axi_awaddr_i,    // Write address
   input  wire logic [2:0]  s_axi_awprot_i,    // Write protection, unused
   input  wire logic        s_axi_awvalid_i,   // Write address valid
   output logic             s_axi_awready_o,   // Write address ready
   input  wire logic [31:0] s_axi_wdata_i,     // Write data
   input  wire logic [3:0]  s_axi_wstrb_i,     // Write strobes
   input  wire logic        s_axi_wvalid_i,    // Write data valid
   output logic             s_axi_wready_o,    // Write data ready
   output logic [1:0]       s_axi_bresp_o,     // Write response
   output logic             s_axi_bvalid_o,    // Write response valid
   input  wire logic        s_axi_bready_i,    // Write response ready
   input  wire logic [11:0] s_axi_araddr_i,    // Read address
   input  wire logic [2:0]  s_axi_arprot_i,    // Read protection, unused
   input  wire logic        s_axi_arvalid_i,   // Read address valid
   output logic             s_axi_arready_o,   // Read address ready
   output logic [31:0]      s_axi_rdata_o,     // Read data
   output logic [1:0]       s_axi_rresp_o,     // Read response
   output logic             s_axi_rvalid_o,    // Read valid
   input  wire logic        s_axi_rready_i,    // Read ready
   output logic             nvm_rd_req_o,      // Lockout byte fetch request
   output logic [17:0]      nvm_addr_o,        // Lockout byte address
   input  wire logic        nvm_rd_valid_i,    // Fetch answer strobe
   input  wire logic [7:0]  nvm_rd_data_i,     // Fetched lockout byte
   input  wire logic        nvm_dbl_fault_i,   // Double fault on fetched phrase
   input  wire logic        backdoor_unlock_i, // Backdoor key match pulse
   output logic             cmd_launch_o,      // Command start pulse
   input  wire logic        cmd_done_i,        // Command finished pulse
   input  wire logic        array_rd_i,        // Array read pulse
   input  wire logic        ecc_single_i,      // Real single fault on this read
   input  wire logic        ecc_double_i,      // Real double fault on this read
   input  wire logic [17:0] ecc_addr_i,        // Address of this read
   output logic             key_access_en_o,   // Backdoor key access enabled
   output logic             unlocked_o,        // Protection state unlocked
   output logic             cmd_irq_o,         // Command done interrupt
   output logic             dbl_irq_o,         // Double fault interrupt
   output logic             sgl_irq_o          // Single fault interrupt
);
   flk_load_t                ld_state_reg;
   logic [7:0]               lock_reg;
   logic [`FLK_CIDX_W-1:0]   cidx_reg;
   logic                     cmdie_reg, ignore_single_fault_reg, fdf_reg, fsf_reg;
   logic                     die_reg, sie_reg;
   logic                     done_reg, dflag_reg, sflag_reg;
   logic [`FLK_CAPT_W-1:0]   capt_reg;
   logic                     aw_held_reg, w_held_reg;
   logic [9:0]               aw_idx_reg, ar_idx_reg;
   logic [31:0]              wdata_reg;
   logic [3:0]               wstrb_reg;
   logic                     rd_stage_reg;
   logic [15:0]              mem_rdata;

   // Bus handshakes; one write and one read in flight at a time
   wire aw_hs    = s_axi_awvalid_i & s_axi_awready_o;
   wire w_hs     = s_axi_wvalid_i & s_axi_wready_o;
   wire ar_hs    = s_axi_arvalid_i & s_axi_arready_o;
   wire wr_do    = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
   wire aw_held_next = (aw_held_reg & ~wr_do) | aw_hs;
   wire w_held_next  = (w_held_reg & ~wr_do) | w_hs;
   wire bvalid_next  = (s_axi_bvalid_o & ~s_axi_bready_i) | wr_do;
   wire rvalid_next  = (s_axi_rvalid_o & ~s_axi_rready_i) | rd_stage_reg;

   // Write decode
   wire wa_lock  = aw_idx_reg == `FLK_IDX_LOCK;
   wire wa_cidx  = aw_idx_reg == `FLK_IDX_CIDX;
   wire wa_spare = aw_idx_reg == `FLK_IDX_SPARE;
   wire wa_cfg   = aw_idx_reg == `FLK_IDX_CFG;
   wire wa_firq  = aw_idx_reg == `FLK_IDX_FIRQ;
   wire wa_opst  = aw_idx_reg == `FLK_IDX_OPST;
   wire wa_fsts  = aw_idx_reg == `FLK_IDX_FSTS;
   wire wa_cword = aw_idx_reg == `FLK_IDX_CWORD;
   wire wa_capt  = aw_idx_reg == `FLK_IDX_CAPT;
   wire wa_hit   = wa_lock | wa_cidx | wa_spare | wa_cfg | wa_firq | wa_opst | wa_fsts | wa_cword | wa_capt;
   wire wr_b0    = wr_do & wstrb_reg[0];

   // Read decode
   wire ra_lock  = ar_idx_reg == `FLK_IDX_LOCK;
   wire ra_cidx  = ar_idx_reg == `FLK_IDX_CIDX;
   wire ra_spare = ar_idx_reg == `FLK_IDX_SPARE;
   wire ra_cfg   = ar_idx_reg == `FLK_IDX_CFG;
   wire ra_firq  = ar_idx_reg == `FLK_IDX_FIRQ;
   wire ra_opst  = ar_idx_reg == `FLK_IDX_OPST;
   wire ra_fsts  = ar_idx_reg == `FLK_IDX_FSTS;
   wire ra_cword = ar_idx_reg == `FLK_IDX_CWORD;
   wire ra_capt  = ar_idx_reg == `FLK_IDX_CAPT;
   wire ra_hit   = ra_lock | ra_cidx | ra_spare | ra_cfg | ra_firq | ra_opst | ra_fsts | ra_cword | ra_capt;

   wire [7:0] cfg_word  = {cmdie_reg, 2'b00, ignore_single_fault_reg, 2'b00, fdf_reg, fsf_reg};
   wire [31:0] rd_word  =
      ra_lock  ? {24'h000000, lock_reg} :
      ra_cidx  ? {29'h00000000, cidx_reg} :
      ra_cfg   ? {24'h000000, cfg_word} :
      ra_firq  ? {30'h00000000, die_reg, sie_reg} :
      ra_opst  ? {24'h000000, done_reg, 7'h00} :
      ra_fsts  ? {30'h00000000, dflag_reg, sflag_reg} :
      ra_cword ? {16'h0000, mem_rdata} :
      ra_capt  ? {14'h0000, capt_reg} : 32'h00000000;

   // Reset load of the lockout byte
   wire ld_take  = (ld_state_reg == LD_REQ) & nvm_rd_valid_i;
   wire ld_done  = ld_state_reg == LD_DONE;
   wire bd_force = backdoor_unlock_i & ld_done;

   // Launch needs a finished command; a finish in the same cycle keeps the flag set
   wire launch   = wr_b0 & wa_opst & wdata_reg[`FLK_OPST_DONE] & done_reg & ld_done;
   wire done_set = cmd_done_i | ld_take;

   // Fault events; the ignore bit also masks forced single faults
   wire sgl_real = array_rd_i & ecc_single_i & ~ignore_single_fault_reg;
   wire sgl_evt  = array_rd_i & (fsf_reg | ecc_single_i) & ~ignore_single_fault_reg;
   wire dbl_evt  = array_rd_i & (fdf_reg | ecc_double_i);
   wire fsts_w1c = wr_b0 & wa_fsts;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         aw_held_reg     <= 1'b0;
         w_held_reg      <= 1'b0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `FLK_RESP_OKAY;
      end else begin
         aw_held_reg     <= aw_held_next;
         w_held_reg      <= w_held_next;
         s_axi_awready_o <= ~aw_held_next & ~bvalid_next;
         s_axi_wready_o  <= ~w_held_next & ~bvalid_next;
         s_axi_bvalid_o  <= bvalid_next;
         if (wr_do) begin
            s_axi_bresp_o <= wa_hit ? `FLK_RESP_OKAY : `FLK_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (aw_hs) begin
         aw_idx_reg <= s_axi_awaddr_i[11:2];
      end
      if (w_hs) begin
         wdata_reg <= s_axi_wdata_i;
         wstrb_reg <= s_axi_wstrb_i;
      end
      if (ar_hs) begin
         ar_idx_reg <= s_axi_araddr_i[11:2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rd_stage_reg    <= 1'b0;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= `FLK_RESP_OKAY;
      end else begin
         rd_stage_reg    <= ar_hs;
         s_axi_arready_o <= ~ar_hs & ~rd_stage_reg & ~rvalid_next;
         s_axi_rvalid_o  <= rvalid_next;
         if (rd_stage_reg) begin
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= ra_hit ? `FLK_RESP_OKAY : `FLK_RESP_SLVERR;
         end
      end
   end

   // Lockout register has no software write path; only the reset load and the backdoor change it
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ld_state_reg <= LD_START;
         nvm_rd_req_o <= 1'b0;
         nvm_addr_o   <= `FLK_LOCK_ADDR;
         lock_reg     <= `FLK_LOCK_RST;
      end else begin
         unique case (ld_state_reg)
            LD_START: begin
               ld_state_reg <= LD_REQ;
               nvm_rd_req_o <= 1'b1;
            end
            LD_REQ: begin
               if (nvm_rd_valid_i) begin
                  ld_state_reg <= LD_DONE;
                  nvm_rd_req_o <= 1'b0;
                  lock_reg     <= nvm_dbl_fault_i ? `FLK_LOCK_ALL : nvm_rd_data_i;
               end
            end
            LD_DONE: begin
               if (bd_force) begin
                  lock_reg[`FLK_PROT_HI:`FLK_PROT_LO] <= `FLK_PAT_ON;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         key_access_en_o <= 1'b0;
         unlocked_o      <= 1'b0;
      end else begin
         key_access_en_o <= lock_reg[`FLK_KEY_HI:`FLK_KEY_LO] == `FLK_PAT_ON;
         unlocked_o      <= lock_reg[`FLK_PROT_HI:`FLK_PROT_LO] == `FLK_PAT_ON;
      end
   end

   // Configuration; force bits change only through software writes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cidx_reg  <= `FLK_CIDX_RST;
         cmdie_reg <= `FLK_CFG_RST;
         ignore_single_fault_reg <= `FLK_CFG_RST;
         fdf_reg   <= `FLK_CFG_RST;
         fsf_reg   <= `FLK_CFG_RST;
         die_reg   <= `FLK_CFG_RST;
         sie_reg   <= `FLK_CFG_RST;
      end else begin
         if (wr_b0 && wa_cidx) begin
            cidx_reg <= wdata_reg[`FLK_CIDX_W-1:0];
         end
         if (wr_b0 && wa_cfg) begin
            cmdie_reg <= wdata_reg[`FLK_CFG_CMDIE];
            ignore_single_fault_reg <= wdata_reg[`FLK_CFG_IGNORE_SINGLE_FAULT];
            fdf_reg   <= wdata_reg[`FLK_CFG_FDF];
            fsf_reg   <= wdata_reg[`FLK_CFG_FSF];
         end
         if (wr_b0 && wa_firq) begin
            die_reg <= wdata_reg[`FLK_FIRQ_DIE];
            sie_reg <= wdata_reg[`FLK_FIRQ_SIE];
         end
      end
   end

   // Flags: hardware set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_reg     <= 1'b0;
         cmd_launch_o <= 1'b0;
         dflag_reg    <= 1'b0;
         sflag_reg    <= 1'b0;
         capt_reg     <= '0;
      end else begin
         done_reg     <= (done_reg & ~launch) | done_set;
         cmd_launch_o <= launch;
         dflag_reg    <= (dflag_reg & ~(fsts_w1c & wdata_reg[`FLK_FSTS_DF])) | dbl_evt;
         sflag_reg    <= (sflag_reg & ~(fsts_w1c & wdata_reg[`FLK_FSTS_SF])) | sgl_evt;
         if ((array_rd_i && ecc_double_i) || sgl_real) begin
            capt_reg <= ecc_addr_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cmd_irq_o <= 1'b0;
         dbl_irq_o <= 1'b0;
         sgl_irq_o <= 1'b0;
      end else begin
         cmd_irq_o <= cmdie_reg & done_reg;
         dbl_irq_o <= die_reg & dflag_reg;
         sgl_irq_o <= sie_reg & sflag_reg;
      end
   end

   // Software reaches the word picked by the index field
   flk_cmd_mem u_cmd_mem (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .we_i    (wr_do & wa_cword),
      .wbe_i   (wstrb_reg[1:0]),
      .waddr_i (cidx_reg),
      .wdata_i (wdata_reg[15:0]),
      .re_i    (ar_hs),
      .raddr_i (cidx_reg),
      .rdata_o (mem_rdata)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_unlock;
      bd_force ##1 (lock_reg[1:0] == 2'b10);
   endsequence
   property p_backdoor;
      s_unlock |=> unlocked_o;
   endproperty
   a_backdoor: assert property (p_backdoor) else $error("backdoor unlock not seen");

   property p_lock_ro;
      (ld_done && !bd_force) |=> $stable(lock_reg);
   endproperty
   a_lock_ro: assert property (p_lock_ro) else $error("lockout changed without cause");

   property p_lock_load;
      (ld_take && !nvm_dbl_fault_i) |=> (lock_reg == $past(nvm_rd_data_i));
   endproperty
   a_lock_load: assert property (p_lock_load) else $error("lockout byte not loaded");

   property p_lock_dbl;
      (ld_take && nvm_dbl_fault_i) |=> (lock_reg == 8'hff) ##1 !key_access_en_o && !unlocked_o;
   endproperty
   a_lock_dbl: assert property (p_lock_dbl) else $error("faulty load not fully locked");

   property p_key_dec;
      ##1 key_access_en_o == ($past(lock_reg[7:6]) == 2'b10);
   endproperty
   a_key_dec: assert property (p_key_dec) else $error("key enable decode wrong");

   property p_spare;
      (rd_stage_reg && ra_spare) |=> (s_axi_rdata_o == 32'h00000000);
   endproperty
   a_spare: assert property (p_spare) else $error("spare register not zero");

   property p_cidx_rd;
      (rd_stage_reg && ra_cidx) |=> (s_axi_rdata_o[31:3] == 29'h0) && (s_axi_rdata_o[2:0] == $past(cidx_reg));
   endproperty
   a_cidx_rd: assert property (p_cidx_rd) else $error("index readback wrong");

   property p_cmd_irq;
      (cmdie_reg && done_reg) |=> cmd_irq_o;
   endproperty
   a_cmd_irq: assert property (p_cmd_irq) else $error("command interrupt missing");

   property p_force_dbl;
      (array_rd_i && fdf_reg) |=> dflag_reg ##1 (dbl_irq_o || !$past(die_reg));
   endproperty
   a_force_dbl: assert property (p_force_dbl) else $error("forced double fault lost");

   property p_ignore;
      (array_rd_i && ignore_single_fault_reg && !sflag_reg) |=> !sflag_reg;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored single fault reported");

   property p_capt;
      (array_rd_i && !ecc_double_i && !ecc_single_i) |=> $stable(capt_reg);
   endproperty
   a_capt: assert property (p_capt) else $error("capture changed on forced fault");

   property p_launch;
      (launch && !done_set) |=> (!done_reg && cmd_launch_o) ##1 !cmd_launch_o;
   endproperty
   a_launch: assert property (p_launch) else $error("launch not one cycle or flag high");
endmodule

/* verification/flk_nvm_model.sv */
// Nonvolatile lockout byte source answering the reset-time fetch
`timescale 1ns/1ps
module flk_nvm_model (
   input  wire logic       clk_i,   // Bus clock
   input  wire logic       req_i,   // Fetch request level
   input  wire logic [7:0] byte_i,  // Stored lockout byte
   input  wire logic       dbl_i,   // Report a double fault
   input  wire logic       slow_i,  // Answer after a delay
   output logic            valid_o, // Answer strobe
   output logic [7:0]      data_o,  // Fetched byte
   output logic            dbl_o    // Double fault flag
);
   logic [2:0] cnt;
   logic [7:0] last;
   initial begin
      valid_o = 1'b0;
      data_o = 8'h00;
      dbl_o = 1'b0;
      cnt = 3'h0;
      last = 8'h00;
   end
   always @(posedge clk_i) begin
      valid_o <= 1'b0;
      dbl_o <= 1'b0;
      // Released bus must not keep the old byte
      data_o <= ~last;
      cnt <= 3'h0;
      if (req_i && !valid_o) begin
         cnt <= cnt + 3'h1;
         if (cnt >= (slow_i ? 3'h5 : 3'h0)) begin
            valid_o <= 1'b1;
            data_o <= {byte_i[7:6], 4'hf, byte_i[1:0]};
            last <= {byte_i[7:6], 4'hf, byte_i[1:0]};
            dbl_o <= dbl_i;
            cnt <= 3'h0;
         end
      end
   end
endmodule

/* verification/flk_lockout_tb.sv */
// Register-level testbench of the lockout and fault configuration block
`timescale 1ns/1ps
`include "flk_cfg.svh"
module flk_lockout_tb;
   import flk_pkg::*;
   logic        clk_i = 0, nrst_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, nvm_req, nvm_val, nvm_dbl, launch;
   logic        key_en, unl, cmd_irq, dbl_irq, sgl_irq, nv_dbl = 0, nv_slow = 0;
   logic        backdoor = 0, cmd_done = 0, arr_rd = 0, e_s = 0, e_d = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_v;
   logic [1:0]  bresp, rresp, resp;
   logic [17:0] nvm_addr, e_addr = 0, capt;
   logic [7:0]  nvm_data, nv_byte = 0;
   int          n_fail = 0, total_checks = 0, n_launch = 0;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (launch === 1'b1) n_launch <= n_launch + 1;
   flk_lockout flk_lockout_inst (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .nvm_rd_req_o(nvm_req), .nvm_addr_o(nvm_addr),
      .nvm_rd_valid_i(nvm_val), .nvm_rd_data_i(nvm_data), .nvm_dbl_fault_i(nvm_dbl),
      .backdoor_unlock_i(backdoor), .cmd_launch_o(launch), .cmd_done_i(cmd_done), .array_rd_i(arr_rd),
      .ecc_single_i(e_s), .ecc_double_i(e_d), .ecc_addr_i(e_addr), .key_access_en_o(key_en),
      .unlocked_o(unl), .cmd_irq_o(cmd_irq), .dbl_irq_o(dbl_irq), .sgl_irq_o(sgl_irq));
   flk_nvm_model flk_nvm_model_inst (.clk_i(clk_i), .req_i(nvm_req), .byte_i(nv_byte), .dbl_i(nv_dbl),
      .slow_i(nv_slow), .valid_o(nvm_val), .data_o(nvm_data), .dbl_o(nvm_dbl));
   task test_done();
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task wr(input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task rd(input logic [9:0] idx);
      @(posedge clk_i);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rd_v = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   task do_reset(input logic [7:0] b, input logic d, input logic s);
      nv_byte <= b;
      nv_dbl <= d;
      nv_slow <= s;
      nrst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      while (nvm_req !== 1'b1) @(posedge clk_i);
      chk("nvm_addr", 32'h3ff0f, {14'h0, nvm_addr});
      while (nvm_req === 1'b1) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
   endtask
   task flt(input logic [7:0] c, input logic s, input logic d, input logic [17:0] a, input logic [1:0] f);
      wr(`FLK_IDX_CFG, {24'h0, c});
      @(posedge clk_i);
      arr_rd <= 1'b1;
      e_s <= s;
      e_d <= d;
      e_addr <= a;
      @(posedge clk_i);
      arr_rd <= 1'b0;
      e_s <= 1'b0;
      e_d <= 1'b0;
      e_addr <= ~a;
      if (d || (s && !c[4])) capt = a;
      rd(`FLK_IDX_FSTS);
      chk("flags", {30'h0, f}, rd_v);
      chkb("dbl_irq", f[1], dbl_irq);
      chkb("sgl_irq", f[0], sgl_irq);
      rd(`FLK_IDX_CFG);
      chk("cfg_kept", {24'h0, c}, rd_v);
      rd(`FLK_IDX_CAPT);
      chk("capture", {14'h0, capt}, rd_v);
      wr(`FLK_IDX_FSTS, 32'h3);
   endtask
   initial begin
      // Covers six resets plus about ninety bus transfers
      repeat (20000) @(posedge clk_i);
      n_fail++;
      test_done();
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset({i[1:0], 4'h0, i[1:0]}, 1'b0, i[0]);
         rd(`FLK_IDX_LOCK);
         chk("lock", {24'h0, i[1:0], 4'hf, i[1:0]}, rd_v);
         chkb("key_en", i == 2, key_en);
         chkb("unlocked", i == 2, unl);
      end
      do_reset(8'h82, 1'b1, 1'b0);
      rd(`FLK_IDX_LOCK);
      chk("lock_dbl", 32'hff, rd_v);
      chkb("key_dbl", 1'b0, key_en);
      do_reset(8'h41, 1'b0, 1'b1);
      rd(`FLK_IDX_CIDX);
      chk("cidx_rst", 32'h0, rd_v);
      rd(`FLK_IDX_CFG);
      chk("cfg_rst", 32'h0, rd_v);
      wr(`FLK_IDX_LOCK, 32'h0);
      chk("lock_wr_resp", {30'h0, `FLK_RESP_OKAY}, {30'h0, resp});
      rd(`FLK_IDX_LOCK);
      chk("lock_ro", 32'h7d, rd_v);
      @(posedge clk_i);
      backdoor <= 1'b1;
      @(posedge clk_i);
      backdoor <= 1'b0;
      rd(`FLK_IDX_LOCK);
      chk("lock_bd", 32'h7e, rd_v);
      chkb("unl_bd", 1'b1, unl);
      wr(`FLK_IDX_CIDX, 32'hff);
      rd(`FLK_IDX_CIDX);
      chk("cidx", 32'h7, rd_v);
      for (int j = 0; j < 8; j++) begin
         wr(`FLK_IDX_CIDX, j);
         wr(`FLK_IDX_CWORD, 32'hc3a0 + j);
      end
      for (int j = 7; j >= 0; j--) begin
         wr(`FLK_IDX_CIDX, j);
         rd(`FLK_IDX_CWORD);
         chk("cword", 32'hc3a0 + j, rd_v);
      end
      wr(`FLK_IDX_SPARE, 32'hff);
      rd(`FLK_IDX_SPARE);
      chk("spare", 32'h0, rd_v);
      rd(10'h3ff);
      chk("unmapped", {30'h0, `FLK_RESP_SLVERR}, {30'h0, resp});
      wr(10'h3ff, 32'h0);
      chk("unmapped_wr", {30'h0, `FLK_RESP_SLVERR}, {30'h0, resp});
      wr(`FLK_IDX_CFG, 32'hff);
      rd(`FLK_IDX_CFG);
      chk("cfg_mask", 32'h93, rd_v);
      wr(`FLK_IDX_FIRQ, 32'h3);
      flt(8'h00, 1'b1, 1'b0, 18'h1a5a5, 2'b01);
      flt(8'h02, 1'b0, 1'b0, 18'h0abcd, 2'b10);
      flt(8'h01, 1'b0, 1'b0, 18'h0abcd, 2'b01);
      flt(8'h00, 1'b0, 1'b0, 18'h0abcd, 2'b00);
      flt(8'h11, 1'b0, 1'b0, 18'h0abcd, 2'b00);
      flt(8'h10, 1'b1, 1'b0, 18'h002c3, 2'b00);
      flt(8'h00, 1'b0, 1'b1, 18'h3ff00, 2'b10);
      wr(`FLK_IDX_CFG, 32'h80);
      // Registered interrupt and launch counter settle one edge after the response
      @(posedge clk_i);
      chkb("cmd_irq_on", 1'b1, cmd_irq);
      wr(`FLK_IDX_OPST, 32'h80);
      @(posedge clk_i);
      chk("launches", 32'h1, n_launch);
      rd(`FLK_IDX_OPST);
      chk("busy", 32'h0, rd_v & 32'h80);
      chkb("cmd_irq_busy", 1'b0, cmd_irq);
      @(posedge clk_i);
      cmd_done <= 1'b1;
      @(posedge clk_i);
      cmd_done <= 1'b0;
      rd(`FLK_IDX_OPST);
      chk("done", 32'h80, rd_v & 32'h80);
      chkb("cmd_irq_done", 1'b1, cmd_irq);
      wr(`FLK_IDX_CFG, 32'h0);
      @(posedge clk_i);
      chkb("cmd_irq_off", 1'b0, cmd_irq);
      test_done();
   end
endmodule
